// ==== hw/oovp_defs.vh ====
// Constants for the output over-voltage protection block
`ifndef OOVP_DEFS_VH
`define OOVP_DEFS_VH
// Register byte offsets
`define OOVP_REG_STATUS     8'h00
`define OOVP_REG_MASK       8'h04
`define OOVP_REG_CTRL       8'h08
`define OOVP_REG_STATE      8'h0c
`define OOVP_REG_LIMIT      8'h10
// Status / mask bit positions
`define OOVP_EV_LATCH       0
`define OOVP_EV_RELEASE     1
`define OOVP_EV_STARTHOLD   2
`define OOVP_EV_SOFTSTART   3
`define OOVP_EV_BITS        4
// Control bit positions
`define OOVP_CTRL_ENABLE    0
`define OOVP_CTRL_RESET_VAL 1'b1
// Reset values
`define OOVP_MASK_RESET     4'h0
// Switching instances needed to latch a fault
`define OOVP_INSTANCES      3'h5
`define OOVP_CNT_W          3
// Synchroniser stages for pin inputs
`define OOVP_SYNC_STAGES    3
`endif

// ==== hw/oovp_sync.v ====
// Three-stage pin synchroniser with agreement filter
module oovp_sync #(
   parameter RESET_VAL = 1'b0
) (
   input  wire clk_i,
   input  wire rst_i,
   input  wire pin_i,
   output wire level_o
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   reg lvl_q;

   ////////////////////////////////////////////////////////////////////////
   // Stage chain; level moves only when stages two and three agree
   always @(posedge clk_i) begin
      if (rst_i) begin
         s1_q  <= RESET_VAL;
         s2_q  <= RESET_VAL;
         s3_q  <= RESET_VAL;
         lvl_q <= RESET_VAL;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            lvl_q <= s3_q;
         end
      end
   end

   assign level_o = lvl_q;
endmodule // oovp_sync

// ==== hw/oovp_wb_regs.v ====
// Wishbone classic register slave for the protection block
`include "oovp_defs.vh"
module oovp_wb_regs (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output wire [31:0] wb_dat_o,
   output wire        wb_ack_o,
   input  wire [3:0]  events_i,
   input  wire [7:0]  state_i,
   input  wire [2:0]  limit_i,
   output wire        enable_o,
   output wire        irq_o
);
   reg [3:0]  status_q;
   reg [3:0]  mask_q;
   reg        enable_q;
   reg        ack_q;
   reg [31:0] dat_q;
   wire       req;
   wire       wr;
   wire [3:0] clr;

   assign req = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr  = req & wb_we_i & wb_sel_i[0];
   assign clr = (wr && wb_adr_i == `OOVP_REG_STATUS) ? wb_dat_i[3:0] : 4'h0;

   ////////////////////////////////////////////////////////////////////////
   // Registers; a new event beats a write-one clear
   always @(posedge clk_i) begin
      if (rst_i) begin
         status_q <= 4'h0;
         mask_q   <= `OOVP_MASK_RESET;
         enable_q <= `OOVP_CTRL_RESET_VAL;
         ack_q    <= 1'b0;
         dat_q    <= 32'h0000_0000;
      end else begin
         ack_q    <= req;
         status_q <= (status_q & ~clr) | events_i;
         if (wr && wb_adr_i == `OOVP_REG_MASK) begin
            mask_q <= wb_dat_i[3:0];
         end
         if (wr && wb_adr_i == `OOVP_REG_CTRL) begin
            enable_q <= wb_dat_i[`OOVP_CTRL_ENABLE];
         end
         // Read mux; unmapped addresses read zero
         case (wb_adr_i)
            `OOVP_REG_STATUS: dat_q <= {28'h0000000, status_q};
            `OOVP_REG_MASK:   dat_q <= {28'h0000000, mask_q};
            `OOVP_REG_CTRL:   dat_q <= {31'h00000000, enable_q};
            `OOVP_REG_STATE:  dat_q <= {24'h000000, state_i};
            `OOVP_REG_LIMIT:  dat_q <= {29'h00000000, limit_i};
            default:          dat_q <= 32'h0000_0000;
         endcase
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign enable_o = enable_q;
   assign irq_o    = |(status_q & mask_q);
endmodule // oovp_wb_regs

// ==== hw/oovp_top.v ====
// Output over-voltage protection logic of a rectifier gate driver
`include "oovp_defs.vh"
module oovp_top #(
   parameter FORCE_LEVEL = 1'b1,        // 1: rectifiers on, 0: rectifiers off
   parameter INSTANCES   = `OOVP_INSTANCES
) (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        gate_timing_in_first_i,
   input  wire        gate_timing_in_second_i,
   input  wire        sense_above_thresh_i,
   input  wire        sense_cleared_i,
   input  wire        ref_below_startup_i,
   input  wire        ref_discharged_i,
   output reg         gate_drive_out_first_o,
   output reg         gate_drive_out_second_o,
   output wire        ref_discharge_o,
   output wire        soft_start_o,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output wire [31:0] wb_dat_o,
   output wire        wb_ack_o,
   output wire        irq_o
);
   // Operating states
   localparam [1:0] ST_STARTUP = 2'd0;
   localparam [1:0] ST_NORMAL  = 2'd1;
   localparam [1:0] ST_LATCHED = 2'd2;
   localparam [1:0] ST_WAIT_SS = 2'd3;

   wire       in_a;
   wire       in_b;
   wire       fault;
   wire       cleared;
   wire       startup;
   wire       discharged;
   wire       enable;
   reg        in_a_q;
   reg        in_b_q;
   reg [1:0]  state_q;
   reg [1:0]  state_d;
   reg [`OOVP_CNT_W-1:0] cnt_q;
   reg [`OOVP_CNT_W-1:0] cnt_d;
   reg        hold_q;
   reg        ss_q;
   reg [3:0]  ev_d;
   wire       instance_edge;
   wire       one_high;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   oovp_sync u_sync_a (.clk_i(clk_i), .rst_i(rst_i),
      .pin_i(gate_timing_in_first_i), .level_o(in_a));
   oovp_sync u_sync_b (.clk_i(clk_i), .rst_i(rst_i),
      .pin_i(gate_timing_in_second_i), .level_o(in_b));
   oovp_sync u_sync_ov (.clk_i(clk_i), .rst_i(rst_i),
      .pin_i(sense_above_thresh_i), .level_o(fault));
   oovp_sync u_sync_cl (.clk_i(clk_i), .rst_i(rst_i),
      .pin_i(sense_cleared_i), .level_o(cleared));
   oovp_sync #(.RESET_VAL(1'b1)) u_sync_su (.clk_i(clk_i), .rst_i(rst_i),
      .pin_i(ref_below_startup_i), .level_o(startup));
   oovp_sync #(.RESET_VAL(1'b1)) u_sync_dc (.clk_i(clk_i), .rst_i(rst_i),
      .pin_i(ref_discharged_i), .level_o(discharged));

   // Any edge on either timing input is one instance
   assign instance_edge = (in_a ^ in_a_q) | (in_b ^ in_b_q);
   assign one_high      = in_a ^ in_b;

   ////////////////////////////////////////////////////////////////////////
   // State and instance counter, next values
   always @* begin
      state_d = state_q;
      cnt_d   = cnt_q;
      ev_d    = 4'h0;
      case (state_q)
         ST_STARTUP: begin
            cnt_d = {`OOVP_CNT_W{1'b0}};
            if (!startup) begin
               state_d = ST_NORMAL;
            end
         end
         ST_NORMAL: begin
            if (startup) begin
               state_d = ST_STARTUP;
            end else if (!fault || !enable) begin
               cnt_d = {`OOVP_CNT_W{1'b0}};
            end else if (instance_edge) begin
               if (cnt_q == INSTANCES - 1'b1) begin
                  state_d = ST_LATCHED;
                  cnt_d   = {`OOVP_CNT_W{1'b0}};
                  ev_d[`OOVP_EV_LATCH] = 1'b1;
               end else begin
                  cnt_d = cnt_q + 1'b1;
               end
            end
         end
         ST_LATCHED: begin
            if (discharged && cleared) begin
               state_d = ST_WAIT_SS;
               ev_d[`OOVP_EV_RELEASE] = 1'b1;
            end
         end
         ST_WAIT_SS: begin
            if (discharged && one_high) begin
               state_d = ST_STARTUP;
               ev_d[`OOVP_EV_SOFTSTART] = 1'b1;
            end
         end
         default: begin
            state_d = ST_STARTUP;
         end
      endcase
      if (state_q == ST_STARTUP && fault && !hold_q) begin
         ev_d[`OOVP_EV_STARTHOLD] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State registers and start-up hold flag
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_STARTUP;
         cnt_q   <= {`OOVP_CNT_W{1'b0}};
         in_a_q  <= 1'b0;
         in_b_q  <= 1'b0;
         hold_q  <= 1'b0;
         ss_q    <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         in_a_q  <= in_a;
         in_b_q  <= in_b;
         ss_q    <= ev_d[`OOVP_EV_SOFTSTART];
         // Start-up fault holds outputs low until normal mode
         if (state_q != ST_STARTUP) begin
            hold_q <= 1'b0;
         end else if (fault) begin
            hold_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Driver outputs, registered
   always @(posedge clk_i) begin
      if (rst_i) begin
         gate_drive_out_first_o  <= 1'b0;
         gate_drive_out_second_o <= 1'b0;
      end else if (state_q == ST_LATCHED) begin
         gate_drive_out_first_o  <= FORCE_LEVEL;
         gate_drive_out_second_o <= FORCE_LEVEL;
      end else if (state_q == ST_WAIT_SS || hold_q ||
                   (state_q == ST_STARTUP && fault)) begin
         gate_drive_out_first_o  <= 1'b0;
         gate_drive_out_second_o <= 1'b0;
      end else begin
         gate_drive_out_first_o  <= in_a;
         gate_drive_out_second_o <= in_b;
      end
   end

   assign ref_discharge_o = (state_q == ST_LATCHED);
   assign soft_start_o    = ss_q;

   ////////////////////////////////////////////////////////////////////////
   // Register slave and interrupt
   oovp_wb_regs u_regs (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .wb_cyc_i (wb_cyc_i),
      .wb_stb_i (wb_stb_i),
      .wb_we_i  (wb_we_i),
      .wb_adr_i (wb_adr_i),
      .wb_sel_i (wb_sel_i),
      .wb_dat_i (wb_dat_i),
      .wb_dat_o (wb_dat_o),
      .wb_ack_o (wb_ack_o),
      .events_i (ev_d),
      .state_i  ({1'b0, hold_q, fault, startup, discharged, cleared,
                  state_q}),
      .limit_i  (cnt_q),
      .enable_o (enable),
      .irq_o    (irq_o)
   );
endmodule // oovp_top

// ==== verification/oovp_props.sv ====
// Port-level assertions of the over-voltage protection block
module oovp_props #(
   parameter FORCE_LEVEL = 1'b1
) (
   input wire clk_i,
   input wire rst_i,
   input wire gate_timing_in_first_i,
   input wire gate_timing_in_second_i,
   input wire sense_above_thresh_i,
   input wire sense_cleared_i,
   input wire ref_below_startup_i,
   input wire ref_discharged_i,
   input wire gate_drive_out_first_o,
   input wire gate_drive_out_second_o,
   input wire ref_discharge_o,
   input wire soft_start_o,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////
   // Input histories long enough to pass the synchronisers
   sequence s_start_fault;
      (ref_below_startup_i && sense_above_thresh_i && !ref_discharge_o)[*6];
   endsequence
   sequence s_quiet;
      ($stable(gate_timing_in_first_i)
       && $stable(gate_timing_in_second_i))[*8];
   endsequence
   sequence s_hold;
      (ref_discharge_o && !(ref_discharged_i && sense_cleared_i))[*6];
   endsequence
   sequence s_no_ss;
      (!ref_discharged_i
       || gate_timing_in_first_i == gate_timing_in_second_i)[*6];
   endsequence
   ////////////////////////////////////////////////////////////////////////
   // Checks
   chk_start_hold: assert property (s_start_fault |->
      !gate_drive_out_first_o && !gate_drive_out_second_o)
      else $error("outputs not held low in start-up fault");
   chk_no_startup_latch: assert property (
      ref_below_startup_i[*8] |-> !$rose(ref_discharge_o))
      else $error("latch set in start-up mode");
   chk_forced_level: assert property (
      ref_discharge_o && $past(ref_discharge_o) |->
      gate_drive_out_first_o == FORCE_LEVEL
      && gate_drive_out_second_o == FORCE_LEVEL)
      else $error("outputs not forced while latched");
   chk_quiet_latch: assert property (s_quiet |->
      !$rose(ref_discharge_o))
      else $error("latch set without switching");
   chk_fault_latch: assert property (
      (!sense_above_thresh_i)[*8] |-> !$rose(ref_discharge_o))
      else $error("latch set without fault");
   chk_latch_stands: assert property (s_hold |=> ref_discharge_o)
      else $error("latch dropped early");
   chk_latch_clears: assert property (
      (ref_discharged_i && sense_cleared_i)[*8] |-> !ref_discharge_o)
      else $error("latch not cleared");
   chk_soft_gate: assert property (s_no_ss |-> !soft_start_o)
      else $error("soft-start without its condition");
   chk_ss_released: assert property (soft_start_o |->
      !ref_discharge_o ##1 !soft_start_o)
      else $error("soft-start pulse wrong");
   chk_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
      wb_ack_o ##1 !wb_ack_o)
      else $error("bus answer not one cycle");
endmodule // oovp_props

// ==== verification/oovp_primary.sv ====
// Primary controller and reference capacitor model
module oovp_primary (
   input  wire  clk_i,
   input  wire  run_i,
   input  wire  step_i,
   input  wire  dis_i,
   input  wire  ss_i,
   output logic tin_a_o,
   output logic tin_b_o,
   output logic below_o,
   output logic dischd_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ph_q = 2'h1;
   logic [3:0] div_q = 4'h0;
   logic       chg_q = 1'b1;
   int         lvl_q = 0;
   ////////////////////////////////////////////////////////////////////////
   // Phases: first high, dead time, second high, dead time
   always @(posedge clk_i) begin
      div_q <= div_q + 4'h1;
      if ((run_i && div_q == 4'hf) || step_i)
         ph_q <= ph_q + 2'h1;
   end
   assign tin_a_o = (ph_q == 2'h0);
   assign tin_b_o = (ph_q == 2'h2);
   // Reference ramps after soft-start, falls while discharged
   always @(posedge clk_i) begin
      if (dis_i)
         chg_q <= 1'b0;
      else if (ss_i)
         chg_q <= 1'b1;
      if (dis_i && lvl_q > 1)
         lvl_q <= lvl_q - 2;
      else if (chg_q && !dis_i && lvl_q < 100)
         lvl_q <= lvl_q + 1;
   end
   assign below_o  = (lvl_q < 90);
   assign dischd_o = (lvl_q <= 20);
endmodule // oovp_primary

// ==== verification/oovp_top_tb_top.sv ====
// Self-checking bench of the protection block
`include "oovp_defs.vh"
module oovp_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int INST = 5;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        run = 1'b1;
   logic        step = 1'b0;
   logic        above = 1'b0;
   logic        clred = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rng = 32'h00013c1f; // Seed 80927
   logic [31:0] rdat;
   logic        tin_a, tin_b, below, dischd, out_a, out_b, dis, ss, ack, irq;
   int          num_errors = 0;
   int          n_checks = 0;
   int          n_ss = 0;
   // Clock and soft-start pulse count
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) if (ss === 1'b1) n_ss <= n_ss + 1;
   oovp_top #(.FORCE_LEVEL(1'b1), .INSTANCES(INST)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i),
      .gate_timing_in_first_i(tin_a), .gate_timing_in_second_i(tin_b),
      .sense_above_thresh_i(above), .sense_cleared_i(clred),
      .ref_below_startup_i(below), .ref_discharged_i(dischd),
      .gate_drive_out_first_o(out_a), .gate_drive_out_second_o(out_b),
      .ref_discharge_o(dis), .soft_start_o(ss), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq));
   oovp_primary i_prim (.clk_i(clk_i), .run_i(run), .step_i(step),
      .dis_i(dis), .ss_i(ss), .tin_a_o(tin_a), .tin_b_o(tin_b),
      .below_o(below), .dischd_o(dischd));
   ////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic exp_lat(input int n);
      return n >= INST;
   endfunction
   task automatic conclude;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %h vs %h", $time, got, exp);
      end
   endtask
   // One rising edge; stimulus then changes by NBA at that edge
   task automatic tick;
      @(posedge clk_i);
   endtask
   // Classic single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int i;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      for (i = 0; i < 20 && ack !== 1'b1; i++)
         @(posedge clk_i);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (i == 20) begin
         num_errors++;
         conclude();
      end
      tick();
   endtask
   // Bounded wait: 0 latch set, 1 latch clear, 2 reference above start-up level
   task automatic wait_on(input int k);
      int i;
      for (i = 0; i < 400; i++) begin
         if (k == 0 ? dis === 1'b1 : k == 1 ? dis === 1'b0 : below === 1'b0)
            break;
         tick();
      end
      if (i == 400) begin
         num_errors++;
         conclude();
      end
   endtask
   task automatic pulse_step(input int gap);
      step <= 1'b1;
      tick();
      step <= 1'b0;
      repeat (gap) tick();
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [31:0] r;
      int n;
      repeat (10) tick();
      rst_i <= 1'b0;
      tick();
      wb(0, `OOVP_REG_MASK, 0, r);
      check(r, 32'h0);
      wb(0, `OOVP_REG_CTRL, 0, r);
      check(r, 32'h1);
      wb(0, 8'h20, 0, r);
      check(r, 32'h0);
      rng = xs(rng);
      wb(1, `OOVP_REG_MASK, rng, r);
      wb(0, `OOVP_REG_MASK, 0, r);
      check(r, {28'h0, rng[3:0]});
      wb(1, `OOVP_REG_MASK, 32'h1, r);
      above <= 1'b1;
      clred <= 1'b0;
      repeat (20) tick();
      check({out_a, out_b, dis}, 3'h0);
      wait_on(0);
      tick();
      check({out_a, out_b, dis, irq}, 4'hf);
      wb(1, `OOVP_REG_MASK, 32'h0, r);
      check(irq, 1'b0);
      wb(1, `OOVP_REG_MASK, 32'h1, r);
      check(irq, 1'b1);
      run <= 1'b0;
      for (n = 0; n < 4 && (tin_a | tin_b); n++) pulse_step(3);
      repeat (80) tick();
      check(dis, 1'b1);
      above <= 1'b0;
      clred <= 1'b1;
      wait_on(1);
      tick();
      check({out_a, out_b}, 2'h0);
      repeat (20) tick();
      check(n_ss, 0);
      pulse_step(8);
      check(n_ss, 1);
      wb(0, `OOVP_REG_STATUS, 0, r);
      check(r & 32'h9, 32'h9);
      wb(1, `OOVP_REG_STATUS, 32'hf, r);
      wb(0, `OOVP_REG_STATUS, 0, r);
      check(r, 32'h0);
      check(irq, 1'b0);
      wait_on(2);
      above <= 1'b1;
      clred <= 1'b0;
      repeat (3) pulse_step(8);
      above <= 1'b0;
      repeat (8) tick();
      above <= 1'b1;
      repeat (8) tick();
      for (n = 1; n <= INST; n++) begin
         rng = xs(rng);
         pulse_step(8 + rng[2:0]);
         check(dis, exp_lat(n));
      end
      conclude();
   end
endmodule // oovp_top_tb_top
bind oovp_top oovp_props #(.FORCE_LEVEL(FORCE_LEVEL)) i_props (.*);
